// ===== rtl/ipx_pkg.sv
package ipx_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IPX_OFF_PRIO_LOW_GROUP1  = 8'hB2;
	localparam logic [7:0] IPX_OFF_PRIO_HIGH_GROUP1 = 8'hB3;
	localparam logic [7:0] IPX_OFF_PRIO_HIGH_GROUP0 = 8'hB7;
	localparam logic [7:0] IPX_OFF_PRIO_LOW_GROUP0  = 8'hB8;
	localparam logic [7:0] IPX_OFF_CTRL             = 8'hC0;
	localparam logic [7:0] IPX_OFF_IRQ_STATUS       = 8'hC4;
	localparam logic [7:0] IPX_OFF_IRQ_MASK         = 8'hC8;
	localparam logic [7:0] IPX_OFF_VECTOR           = 8'hCC;

	localparam logic [7:0] IPX_PRIO_RESET = 8'h00;
	localparam int         IPX_BLOCK_BIT  = 7;
	localparam logic [7:0] IPX_GROUP1_MASK = 8'hB7;

	// control register fields
	localparam int IPX_CTRL_GIE  = 0;
	localparam int IPX_CTRL_IT0  = 1;
	localparam int IPX_CTRL_IT1  = 2;
	localparam int IPX_CTRL_PD   = 3;

	// source numbering: 0..6 group0 bits, 8..10 and 12..13 group1 bits
	localparam int IPX_NSRC     = 16;
	localparam int IPX_SRC_EXT0 = 0;
	localparam int IPX_SRC_EXT1 = 2;

	// status events
	localparam int IPX_EV_EXT0  = 0;
	localparam int IPX_EV_EXT1  = 1;
	localparam int IPX_EV_VEC   = 2;
	localparam int IPX_EV_WAKE  = 3;
	localparam int IPX_NEV      = 4;

	localparam int IPX_NO_LEVEL = 4;

	typedef struct packed {
		logic       valid;
		logic [3:0] source;
		logic [1:0] level;
	} ipx_vector_type;

	typedef struct packed {
		logic trig_type;
		logic clear;
	} ipx_ext_ctrl_type;

endpackage : ipx_pkg

// ===== rtl/ipx_ext_detect.sv
`timescale 1ns/100ps
`default_nettype none
module ipx_ext_detect
	import ipx_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              ext_request_pin_n,
	input  wire ipx_ext_ctrl_type  ctrl,
	output logic                   request,
	output logic                   edge_seen
);
	logic sample_reg;
	logic prev_reg;
	logic flag_reg;
	logic fall;

	// one sample per clock; edge needs high sample then low sample
	assign fall = prev_reg & ~sample_reg;
	assign edge_seen = fall & ctrl.trig_type;
	// level mode follows the pin sample directly
	assign request = ctrl.trig_type ? flag_reg : ~sample_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_reg <= 1'b1;
			prev_reg   <= 1'b1;
		end else begin
			sample_reg <= ext_request_pin_n;
			prev_reg   <= sample_reg;
		end
	end

	// set wins over vector clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			flag_reg <= 1'b0;
		else if (edge_seen)
			flag_reg <= 1'b1;
		else if (ctrl.clear | ~ctrl.trig_type)
			flag_reg <= 1'b0;
	end

	edge_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.trig_type && prev_reg && !sample_reg |=> flag_reg)
		else $error("edge flag not set");
	level_req_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl.trig_type |-> request == !sample_reg)
		else $error("level request wrong");
	pin_sample_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 sample_reg == $past(ext_request_pin_n))
		else $error("pin not sampled");

endmodule : ipx_ext_detect
`default_nettype wire

// ===== rtl/ipx_irq_prio.sv
`timescale 1ns/100ps
`default_nettype none
module ipx_irq_prio
	import ipx_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [IPX_NSRC-1:0]   src_request,
	input  wire logic [IPX_NSRC-1:0]   src_enable,
	input  wire logic                  ext_request_pin0_n,
	input  wire logic                  ext_request_pin1_n,
	input  wire logic                  vector_ack,
	input  wire logic                  service_done,
	output ipx_vector_type             vector,
	output logic                       wake,
	output logic                       irq
);
	logic [7:0] prio_lo0_reg, prio_hi0_reg, prio_lo1_reg, prio_hi1_reg;
	logic [3:0] ctrl_reg;
	logic [IPX_NEV-1:0] status_reg, mask_reg;
	ipx_vector_type vector_reg;
	logic wake_reg, irq_reg, hready_reg;
	logic [31:0] rdata_reg;
	// in-service stack: one bit per level
	logic [3:0] active_reg;

	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        rd_req;
	logic        wr_req;

	logic [IPX_NSRC-1:0] req_all;
	logic [IPX_NSRC-1:0] prio_lo, prio_hi;
	logic [3:0]  block_bits;
	logic        ext_req0, ext_req1, edge0, edge1;
	ipx_ext_ctrl_type ext_ctrl0, ext_ctrl1;
	ipx_vector_type pick;
	logic [2:0]  served_level;
	logic [IPX_NEV-1:0] events;
	logic [31:0] rd_mux;

	function automatic logic [1:0] level_of(input int s,
		input logic [IPX_NSRC-1:0] hi, input logic [IPX_NSRC-1:0] lo);
		level_of = {hi[s], lo[s]};
	endfunction : level_of

	// group0 maps straight, group1 masked to its used bits
	assign prio_lo = {(prio_lo1_reg & IPX_GROUP1_MASK & 8'h7F),
		(prio_lo0_reg & 8'h7F)};
	assign prio_hi = {(prio_hi1_reg & IPX_GROUP1_MASK & 8'h7F),
		(prio_hi0_reg & 8'h7F)};
	assign block_bits = {prio_hi1_reg[IPX_BLOCK_BIT],
		prio_lo1_reg[IPX_BLOCK_BIT], prio_hi0_reg[IPX_BLOCK_BIT],
		prio_lo0_reg[IPX_BLOCK_BIT]};

	assign ext_ctrl0 = '{trig_type: ctrl_reg[IPX_CTRL_IT0],
		clear: vector_ack && vector_reg.valid &&
		vector_reg.source == 4'(IPX_SRC_EXT0)};
	assign ext_ctrl1 = '{trig_type: ctrl_reg[IPX_CTRL_IT1],
		clear: vector_ack && vector_reg.valid &&
		vector_reg.source == 4'(IPX_SRC_EXT1)};

	ipx_ext_detect u_ext0 (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.ext_request_pin_n (ext_request_pin0_n),
		.ctrl              (ext_ctrl0),
		.request           (ext_req0),
		.edge_seen         (edge0)
	);
	ipx_ext_detect u_ext1 (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.ext_request_pin_n (ext_request_pin1_n),
		.ctrl              (ext_ctrl1),
		.request           (ext_req1),
		.edge_seen         (edge1)
	);

	always_comb begin
		req_all = src_request & src_enable;
		req_all[IPX_SRC_EXT0] = ext_req0 & src_enable[IPX_SRC_EXT0];
		req_all[IPX_SRC_EXT1] = ext_req1 & src_enable[IPX_SRC_EXT1];
		req_all[7] = 1'b0;
		req_all[11] = 1'b0;
		req_all[14] = 1'b0;
		req_all[15] = 1'b0;
	end

	// highest level in service; pending must exceed it
	always_comb begin
		served_level = 3'(IPX_NO_LEVEL);
		for (int l = 3; l >= 0; l--) begin
			if (active_reg[l] && served_level == 3'(IPX_NO_LEVEL))
				served_level = 3'(l);
		end
	end

	// scan levels low to high so the highest wins; lower source wins tie
	always_comb begin
		logic [1:0] lv;
		lv = 2'b00;
		pick = '0;
		for (int l = 0; l < 4; l++) begin
			for (int s = IPX_NSRC - 1; s >= 0; s--) begin
				lv = level_of(s, prio_hi, prio_lo);
				if (req_all[s] && lv == 2'(l) && !block_bits[l]
					&& ctrl_reg[IPX_CTRL_GIE]
					&& (served_level == 3'(IPX_NO_LEVEL) ||
					3'(l) > served_level)) begin
					pick.valid  = 1'b1;
					pick.source = 4'(s);
					pick.level  = 2'(l);
				end
			end
		end
	end

	assign events = {ctrl_reg[IPX_CTRL_PD] & (ext_req0 | ext_req1),
		vector_ack & vector_reg.valid, edge1 | (ext_req1 &
		~ctrl_reg[IPX_CTRL_IT1]), edge0 | (ext_req0 &
		~ctrl_reg[IPX_CTRL_IT0])};

	assign rd_req = hsel && hready && htrans[1] && !hwrite;
	assign wr_req = hsel && hready && htrans[1] && hwrite;

	always_comb begin
		case (haddr[9:2])
			IPX_OFF_PRIO_LOW_GROUP0:  rd_mux = {24'h0, prio_lo0_reg};
			IPX_OFF_PRIO_HIGH_GROUP0: rd_mux = {24'h0, prio_hi0_reg};
			IPX_OFF_PRIO_LOW_GROUP1:
				rd_mux = {24'h0, prio_lo1_reg & IPX_GROUP1_MASK};
			IPX_OFF_PRIO_HIGH_GROUP1:
				rd_mux = {24'h0, prio_hi1_reg & IPX_GROUP1_MASK};
			IPX_OFF_CTRL:       rd_mux = {28'h0, ctrl_reg};
			IPX_OFF_IRQ_STATUS: rd_mux = {28'h0, status_reg};
			IPX_OFF_IRQ_MASK:   rd_mux = {28'h0, mask_reg};
			IPX_OFF_VECTOR:     rd_mux = {25'h0, vector_reg};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// bus: write data lands one cycle after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
			hready_reg  <= 1'b1;
		end else begin
			wr_pend_reg <= wr_req;
			wr_addr_reg <= haddr[9:2];
			hready_reg  <= 1'b1;
			if (rd_req)
				rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prio_lo0_reg <= IPX_PRIO_RESET;
			prio_hi0_reg <= IPX_PRIO_RESET;
			prio_lo1_reg <= IPX_PRIO_RESET;
			prio_hi1_reg <= IPX_PRIO_RESET;
			ctrl_reg     <= 4'h0;
			mask_reg     <= '0;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				IPX_OFF_PRIO_LOW_GROUP0:  prio_lo0_reg <= hwdata[7:0];
				IPX_OFF_PRIO_HIGH_GROUP0: prio_hi0_reg <= hwdata[7:0];
				IPX_OFF_PRIO_LOW_GROUP1:
					prio_lo1_reg <= hwdata[7:0] & IPX_GROUP1_MASK;
				IPX_OFF_PRIO_HIGH_GROUP1:
					prio_hi1_reg <= hwdata[7:0] & IPX_GROUP1_MASK;
				IPX_OFF_CTRL:     ctrl_reg <= hwdata[3:0];
				IPX_OFF_IRQ_MASK: mask_reg <= hwdata[IPX_NEV-1:0];
				default: ;
			endcase
		end
	end

	// sticky status, set wins over write-one-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status_reg <= '0;
		else if (wr_pend_reg && wr_addr_reg == IPX_OFF_IRQ_STATUS)
			status_reg <= (status_reg & ~hwdata[IPX_NEV-1:0]) | events;
		else
			status_reg <= status_reg | events;
	end

	// vector reloaded from pick every cycle, cleared the cycle after the sequencer acks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_reg <= '0;
			active_reg <= 4'h0;
		end else begin
			vector_reg <= vector_ack ? '0 : pick;
			if (vector_ack && vector_reg.valid)
				active_reg[vector_reg.level] <= 1'b1;
			else if (service_done)
				for (int l = 3; l >= 0; l--)
					if (active_reg[l] && !(|(active_reg >> (l + 1))))
						active_reg[l] <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_reg <= 1'b0;
			irq_reg  <= 1'b0;
		end else begin
			wake_reg <= ctrl_reg[IPX_CTRL_PD] & (ext_req0 | ext_req1);
			irq_reg  <= |(status_reg & mask_reg);
		end
	end

	assign hrdata    = rdata_reg;
	assign hreadyout = hready_reg;
	assign hresp     = 1'b0;
	assign vector    = vector_reg;
	assign wake      = wake_reg;
	assign irq       = irq_reg;

	gie_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl_reg[IPX_CTRL_GIE] && !vector_ack |=> !vector_reg.valid)
		else $error("vector while globally disabled");
	nested_a: assert property (@(posedge hclk) disable iff (!hresetn)
		vector_reg.valid |-> served_level == 3'(IPX_NO_LEVEL) ||
		3'(vector_reg.level) > served_level || $past(vector_ack))
		else $error("vector not above serviced level");
	block_lv_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pick.valid |-> !block_bits[pick.level])
		else $error("blocked level chosen");
	wake_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_reg[IPX_CTRL_PD] && ext_req0 |=> wake)
		else $error("no wake on request");
	prio_rst_a: assert property (@(posedge hclk)
		!hresetn |=> prio_lo0_reg == 8'h00 && prio_hi1_reg == 8'h00)
		else $error("priority reset wrong");

endmodule : ipx_irq_prio
`default_nettype wire

// ===== tb/ipx_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module ipx_partner_model
	import ipx_pkg::*;
(
	input  wire logic           hclk,
	input  wire ipx_vector_type vector,
	output logic                pin0_n,
	output logic                pin1_n,
	output logic                vector_ack,
	output logic                service_done
);
	initial begin
		pin0_n = 1'b1;
		pin1_n = 1'b1;
		vector_ack = 1'b0;
		service_done = 1'b0;
	end

	// a shorter level could fall between two samples
	task automatic set_pin(input int n, input logic v);
		if (n == 0) begin
			pin0_n <= v;
		end else begin
			pin1_n <= v;
		end
		repeat (2) @(posedge hclk);
	endtask : set_pin

	// sequencer only takes a vector that is shown
	task automatic ack(input int dly);
		repeat (dly) @(posedge hclk);
		vector_ack <= vector.valid;
		@(posedge hclk);
		vector_ack <= 1'b0;
	endtask : ack

	task automatic done();
		service_done <= 1'b1;
		@(posedge hclk);
		service_done <= 1'b0;
	endtask : done
endmodule : ipx_partner_model
`default_nettype wire

// ===== tb/tb_irq_priority_ext_detect.sv
`timescale 1ns/100ps
`default_nettype none
module tb_irq_priority_ext_detect
	import ipx_pkg::*;
	;
	logic           hclk;
	logic           hresetn;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [31:0]    hwdata;
	logic [31:0]    hrdata;
	logic           hready;
	logic           hresp;
	logic [15:0]    src_request;
	logic [15:0]    src_enable;
	logic           pin0_n;
	logic           pin1_n;
	logic           vector_ack;
	logic           service_done;
	ipx_vector_type vector;
	logic           wake;
	logic           irq;
	logic           gie;
	logic [31:0]    rdat;
	logic [15:0]    lf;
	logic [7:0]     mv[4];
	logic [7:0]     offs[4];
	int             act_max;
	int             err_count;
	int             comparisons;

	ipx_irq_prio i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .src_request(src_request),
		.src_enable(src_enable), .ext_request_pin0_n(pin0_n),
		.ext_request_pin1_n(pin1_n), .vector_ack(vector_ack),
		.service_done(service_done), .vector(vector), .wake(wake),
		.irq(irq));

	ipx_partner_model i_par (.hclk(hclk), .vector(vector), .pin0_n(pin0_n),
		.pin1_n(pin1_n), .vector_ack(vector_ack),
		.service_done(service_done));

	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt

	// ties go to the lowest index; active level must be beaten strictly
	function automatic logic [6:0] pick(input logic [15:0] req,
		input logic en);
		int lv;
		int best;
		logic [6:0] r;
		r = 7'h00;
		best = act_max;
		for (int s = 0; s < 16; s++) begin
			lv = {mv[2 * (s / 8) + 1][s % 8], mv[2 * (s / 8)][s % 8]};
			if (req[s] && s % 8 != 7 && s != 11 && s != 14 && en
				&& !mv[lv][7] && lv > best) begin
				best = lv;
				r = {1'b1, 4'(s), 2'(lv)};
			end
		end
		return r;
	endfunction : pick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h000000, a, 2'b00};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rdat = hrdata;
	endtask : bus

	// unused group1 bits read back as zero
	task automatic wreg(input int k, input logic [7:0] v);
		mv[k] = v & (k > 1 ? IPX_GROUP1_MASK : 8'hFF);
		bus(1'b1, offs[k], {24'h000000, v});
	endtask : wreg

	task automatic ticks(input int n);
		repeat (n) @(posedge hclk);
	endtask : ticks

	task automatic wait_vec();
		for (int i = 0; i < 20 && vector.valid !== 1'b1; i++)
			@(posedge hclk);
	endtask : wait_vec

	task automatic summarize();
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// whole run is well under a thousand cycles
	initial begin
		#200000;
		err_count++;
		summarize();
	end

	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{src_request, src_enable} = '0;
		act_max = -1;
		err_count = 0;
		comparisons = 0;
		lf = 16'h7BA0;
		offs = '{IPX_OFF_PRIO_LOW_GROUP0, IPX_OFF_PRIO_HIGH_GROUP0,
			IPX_OFF_PRIO_LOW_GROUP1, IPX_OFF_PRIO_HIGH_GROUP1};
		mv = '{default: 8'h00};
		ticks(12);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, offs[k], 32'h0);
			chk(rdat, 32'h0);
		end
		bus(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
		for (int it = 0; it < 12; it++) begin
			for (int k = 0; k < 4; k++) begin
				lf = nxt(lf);
				wreg(k, lf[7:0]);
				bus(1'b0, offs[k], 32'h0);
				chk(rdat, {24'h000000, mv[k]});
			end
			lf = nxt(lf);
			gie = lf[1:0] != 2'h0;
			bus(1'b1, IPX_OFF_CTRL, {31'h0, gie});
			lf = nxt(lf);
			src_request <= lf;
			src_enable <= nxt(lf);
			ticks(3);
			chk(32'(vector), 32'(pick(src_request & src_enable & 16'hFFFA,
				gie)));
		end
		for (int k = 0; k < 4; k++)
			wreg(k, 8'h00);
		wreg(0, 8'h01);
		src_request <= 16'h0000;
		src_enable <= 16'hFFFF;
		bus(1'b1, IPX_OFF_CTRL, 32'h3);
		i_par.set_pin(0, 1'b0);
		wait_vec();
		chk(32'(vector), 32'(pick(16'h0001, 1'b1)));
		i_par.ack(0);
		ticks(2);
		chk(32'(vector), 32'h0);
		bus(1'b0, IPX_OFF_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h5);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, IPX_OFF_IRQ_MASK, 32'h1);
		ticks(2);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, IPX_OFF_IRQ_STATUS, 32'hF);
		ticks(2);
		chk({31'h0, irq}, 32'h0);
		i_par.done();
		i_par.set_pin(0, 1'b1);
		wreg(0, 8'h00);
		bus(1'b1, IPX_OFF_CTRL, 32'h1);
		i_par.set_pin(1, 1'b0);
		wait_vec();
		chk(32'(vector), 32'(pick(16'h0004, 1'b1)));
		i_par.ack(0);
		act_max = 0;
		src_request <= 16'h0002;
		ticks(3);
		chk(32'(vector), 32'(pick(16'h0006, 1'b1)));
		i_par.done();
		act_max = -1;
		ticks(2);
		chk(32'(vector), 32'(pick(16'h0006, 1'b1)));
		src_request <= 16'h0000;
		i_par.set_pin(1, 1'b1);
		ticks(2);
		chk(32'(vector), 32'h0);
		bus(1'b1, IPX_OFF_CTRL, 32'h8);
		for (int n = 0; n < 2; n++) begin
			i_par.set_pin(n, 1'b0);
			ticks(1);
			chk({31'h0, wake}, 32'h1);
			i_par.set_pin(n, 1'b1);
			ticks(1);
			chk({31'h0, wake}, 32'h0);
		end
		chk({31'h0, hresp}, 32'h0);
		summarize();
	end
endmodule : tb_irq_priority_ext_detect
`default_nettype wire
